//--- hdl/smsr_core.sv
// Run-time control (set/clear) and status registers of a fieldbus slave
// controller, on an AHB-Lite slave port.
// Assumes protocol engines consume o_cmd and report on i_stat.
`include "smsr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module smsr_core #(
    parameter logic [3:0] RELEASE_NO = 4'h0, // Arbitrary value
    parameter int GAP_LONG_CYC =
        (`SMSR_GAP_LONG_NS / 1000) * (`SMSR_CLK_HZ / 1000000)
)(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire smsr_pkg::smsr_ahb_req_t i_ahb,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire smsr_pkg::smsr_stat_t i_stat,
    input wire logic i_int_pending,
    input wire logic i_mem_valid,
    input wire logic [10:0] i_mem_addr,
    output logic [10:0] o_mem_addr,
    output var smsr_pkg::smsr_cmd_t o_cmd,
    output logic [15:0] o_wdog_preset,
    output logic o_online,
    output logic o_int_allow
);

    localparam int GAP_SHORT_CYC =
        ((`SMSR_GAP_SHORT_NS * (`SMSR_CLK_HZ / 1000000)) + 999) / 1000;

    typedef enum logic [2:0] {
        SMSR_ST_OFFLINE = 3'h1,
        SMSR_ST_IDLE = 3'h2,
        SMSR_ST_DRAIN = 3'h4
    } smsr_run_t;

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic addr_ok;
    logic ctrl_set_wr;
    logic ctrl_clr_wr;
    logic [5:0] wdata6;

    assign addr_ok = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ok && i_ahb.hwrite;
            wr_idx_reg <= i_ahb.haddr[9:2];
        end
    end

    assign ctrl_set_wr = wr_pend_reg && (wr_idx_reg == `SMSR_IDX_CTRL_SET);
    assign ctrl_clr_wr = wr_pend_reg && (wr_idx_reg == `SMSR_IDX_CTRL_CLR);
    assign wdata6 = i_hwdata[5:0] & `SMSR_CTRL_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Control register

    logic [5:0] ctrl_reg;
    logic [5:0] ctrl_next;
    logic [5:0] self_clr;
    smsr_run_t run_reg;
    logic gap_base_reg;

    always_comb
    begin
        self_clr = 6'h00;
        if (ctrl_reg[`SMSR_BIT_LEAVE_OFF])
        begin
            self_clr[`SMSR_BIT_LEAVE_OFF] = 1'b1;
            self_clr[`SMSR_BIT_GO_OFF] = 1'b1;
        end
        self_clr[`SMSR_BIT_EOI] = ctrl_reg[`SMSR_BIT_EOI];
        if (run_reg == SMSR_ST_DRAIN && !i_stat.request_busy)
            self_clr[`SMSR_BIT_GO_OFF] = 1'b1;
        // cleared when slave FSM reaches await-parameter
        if (i_stat.slave_in_wait_prm)
            self_clr[`SMSR_BIT_FORCE_PRM] = ctrl_reg[`SMSR_BIT_FORCE_PRM];
        self_clr[`SMSR_BIT_WD_RELOAD] = ctrl_reg[`SMSR_BIT_WD_RELOAD];
        // ones set or clear, zeros keep
        ctrl_next = ctrl_reg & ~self_clr;
        if (ctrl_clr_wr)
            ctrl_next = ctrl_next & ~wdata6;
        // Host set wins over hardware self-clear
        if (ctrl_set_wr)
            ctrl_next = ctrl_next | wdata6;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ctrl_reg <= `SMSR_CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary registers: watchdog preset and gap time base

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_wdog_preset <= `SMSR_WDOG_PRESET_RESET;
            gap_base_reg <= 1'b0;
        end
        else if (wr_pend_reg)
        begin
            if (wr_idx_reg == `SMSR_IDX_WDOG_PRESET)
                o_wdog_preset <= i_hwdata[15:0];
            if (wr_idx_reg == `SMSR_IDX_CONFIG)
                gap_base_reg <= i_hwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Online state

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            run_reg <= SMSR_ST_OFFLINE;
        else
        begin
            case (run_reg)
                SMSR_ST_OFFLINE:
                    if (ctrl_reg[`SMSR_BIT_LEAVE_OFF])
                        run_reg <= SMSR_ST_IDLE;
                SMSR_ST_IDLE:
                    if (ctrl_reg[`SMSR_BIT_GO_OFF])
                        run_reg <= SMSR_ST_DRAIN;
                SMSR_ST_DRAIN:
                    if (!i_stat.request_busy)
                        run_reg <= SMSR_ST_OFFLINE;
                default:
                    run_reg <= SMSR_ST_OFFLINE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gap timer

    logic [19:0] gap_cnt_reg;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            gap_cnt_reg <= 20'h00000;
        else if (ctrl_reg[`SMSR_BIT_EOI])
            gap_cnt_reg <= gap_base_reg ? 20'(GAP_LONG_CYC)
                                        : 20'(GAP_SHORT_CYC);
        else if (gap_cnt_reg != 20'h00000)
            gap_cnt_reg <= gap_cnt_reg - 20'h00001;
    end

    assign o_int_allow = (gap_cnt_reg == 20'h00000) &&
                         !ctrl_reg[`SMSR_BIT_EOI] && i_int_pending;

    ////////////////////////////////////////////////////////////////////////
    // Memory wrap and violation flag

    logic viol_reg;

    assign o_mem_addr = (i_mem_addr > `SMSR_RAM_LIMIT) ?
                        (i_mem_addr - `SMSR_RAM_WRAP) : i_mem_addr;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            viol_reg <= 1'b0;
        else if (i_mem_valid && (i_mem_addr > `SMSR_RAM_LIMIT))
            viol_reg <= 1'b1;
        else if (run_reg == SMSR_ST_OFFLINE && ctrl_reg[`SMSR_BIT_LEAVE_OFF])
            viol_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands

    assign o_online = (run_reg != SMSR_ST_OFFLINE);

    always_comb
    begin
        o_cmd.leave_offline_cmd = ctrl_reg[`SMSR_BIT_LEAVE_OFF];
        o_cmd.start_timers = ctrl_reg[`SMSR_BIT_LEAVE_OFF] &&
                             (run_reg == SMSR_ST_OFFLINE);
        o_cmd.go_offline_req = ctrl_reg[`SMSR_BIT_GO_OFF];
        o_cmd.force_wait_prm = ctrl_reg[`SMSR_BIT_FORCE_PRM];
        o_cmd.swap_enable = ctrl_reg[`SMSR_BIT_SWAP_EN];
        o_cmd.user_wdog_reload = ctrl_reg[`SMSR_BIT_WD_RELOAD];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [15:0] status;
    logic rd_ok;

    always_comb
    begin
        status[0] = o_online;
        status[1] = i_stat.link_ind_pending;
        status[2] = i_stat.diag_not_fetched;
        status[3] = viol_reg;
        status[5:4] = i_stat.slave_fsm_state;
        status[7:6] = i_stat.wdog_fsm_state;
        status[11:8] = i_stat.baud_code;
        status[15:12] = RELEASE_NO;
    end

    assign rd_ok = addr_ok && !i_ahb.hwrite;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_hrdata <= 32'h00000000;
        else if (rd_ok)
        begin
            case (i_ahb.haddr[9:2])
                `SMSR_IDX_STATUS_LO:
                    o_hrdata <= {24'h000000, status[7:0]};
                `SMSR_IDX_STATUS_HI:
                    o_hrdata <= {24'h000000, status[15:8]};
                `SMSR_IDX_CTRL_SET,
                `SMSR_IDX_CTRL_CLR:
                    o_hrdata <= {26'h0, ctrl_reg};
                `SMSR_IDX_WDOG_PRESET:
                    o_hrdata <= {16'h0000, o_wdog_preset};
                `SMSR_IDX_CONFIG:
                    o_hrdata <= {31'h0, gap_base_reg};
                default:
                    o_hrdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- hdl/smsr_regs.svh
// Offsets, field positions, reset values and timing constants (clock rate, gap times in ns) for the
// run-time control and status register bank.
// Assumes a 25 MHz clock and an AHB-Lite slave with word-aligned registers.
`ifndef SMSR_REGS_SVH
`define SMSR_REGS_SVH

// Printed offsets are indices; byte address is four times index
`define SMSR_IDX_STATUS_LO 8'h04
`define SMSR_IDX_STATUS_HI 8'h05
`define SMSR_IDX_CTRL_SET 8'h08
`define SMSR_IDX_CTRL_CLR 8'h09
`define SMSR_IDX_WDOG_PRESET 8'h0A
`define SMSR_IDX_CONFIG 8'h0B

`define SMSR_BIT_LEAVE_OFF 0
`define SMSR_BIT_EOI 1
`define SMSR_BIT_GO_OFF 2
`define SMSR_BIT_FORCE_PRM 3
`define SMSR_BIT_SWAP_EN 4
`define SMSR_BIT_WD_RELOAD 5
`define SMSR_CTRL_MASK 6'h3F
`define SMSR_CTRL_RESET 6'h00

`define SMSR_RAM_LIMIT 11'h600
`define SMSR_RAM_WRAP 11'h400

`define SMSR_CLK_HZ 25000000
`define SMSR_GAP_SHORT_NS 1000
`define SMSR_GAP_LONG_NS 1000000
`define SMSR_WDOG_PRESET_RESET 16'hFFFF

`endif

//--- hdl/smsr_pkg.sv
// Types for the run-time control and status register bank.
// Assumes the constants header is included by users that need numbers.
package smsr_pkg;

    typedef enum logic [1:0] {
        SMSR_SLV_WAIT_PRM = 2'h0,
        SMSR_SLV_WAIT_CFG = 2'h1,
        SMSR_SLV_EXCHANGE_STATE = 2'h2
    } smsr_slave_code_t;

    typedef enum logic [1:0] {
        SMSR_WD_RATE_SEARCH = 2'h0,
        SMSR_WD_RATE_MON = 2'h1,
        SMSR_WD_MASTER_MON = 2'h2
    } smsr_wdog_code_t;

    // Commands toward the protocol engines
    typedef struct packed {
        logic leave_offline_cmd;
        logic start_timers;
        logic go_offline_req;
        logic force_wait_prm;
        logic swap_enable;
        logic user_wdog_reload;
    } smsr_cmd_t;

    // State reported by the protocol engines
    typedef struct packed {
        logic request_busy;
        logic link_ind_pending;
        logic diag_not_fetched;
        logic [1:0] slave_fsm_state;
        logic [1:0] wdog_fsm_state;
        logic [3:0] baud_code;
        logic slave_in_wait_prm;
    } smsr_stat_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } smsr_ahb_req_t;

endpackage

//--- test/smsr_engine_model.sv
// Behavioural protocol engines answering the command outputs.
// Assumes static status fields come from the bench on i_base.
`timescale 1ns/1ps
`default_nettype none
module smsr_engine_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire smsr_pkg::smsr_cmd_t i_cmd,
    input wire smsr_pkg::smsr_stat_t i_base,
    input wire logic [3:0] i_busy_len,
    output var smsr_pkg::smsr_stat_t o_stat
);
    logic [3:0] busy_reg;
    logic prm_reg;
    always_ff @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
            busy_reg <= 4'h0;
        else if (i_cmd.force_wait_prm && !prm_reg)
            busy_reg <= i_busy_len;
        else if (busy_reg != 4'h0)
            busy_reg <= busy_reg - 4'h1;
    always_ff @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
            prm_reg <= 1'h0;
        else if (i_cmd.force_wait_prm)
            prm_reg <= 1'h1;
    always_comb
    begin
        o_stat = i_base;
        o_stat.request_busy = busy_reg != 4'h0;
        o_stat.slave_in_wait_prm = prm_reg;
        if (prm_reg)
            o_stat.slave_fsm_state = 2'h0;
    end
endmodule
`default_nettype wire

//--- test/smsr_checker.sv
// Assertions on the control and status bank ports.
// Assumes binding to smsr_core.
`timescale 1ns/1ps
`default_nettype none
module smsr_checker #(
    parameter logic [3:0] RELEASE_NO = 4'h0,
    parameter int GAP_LONG_CYC = 25000
)(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire smsr_pkg::smsr_ahb_req_t i_ahb,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    input wire smsr_pkg::smsr_stat_t i_stat,
    input wire logic [10:0] i_mem_addr,
    input wire logic [10:0] o_mem_addr,
    input wire smsr_pkg::smsr_cmd_t o_cmd,
    input wire logic o_online,
    input wire logic o_int_allow
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire logic tk = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
    wire logic [31:0] ad = i_ahb.haddr;
    sequence wr_s(a);
        tk && i_ahb.hwrite && ad == a;
    endsequence
    AST_WRAP:
        assert property (o_mem_addr == (i_mem_addr > 11'h600 ?
            i_mem_addr - 11'h400 : i_mem_addr)) else $error("wrap");
    AST_RD_LO:
        assert property (tk && !i_ahb.hwrite && ad == 32'h10 |=>
            o_hrdata[7:4] == $past({i_stat.wdog_fsm_state,
            i_stat.slave_fsm_state}) && o_hrdata[2:0] == $past({
            i_stat.diag_not_fetched, i_stat.link_ind_pending, o_online}))
        else $error("status low");
    AST_RD_HI:
        assert property (tk && !i_ahb.hwrite && ad == 32'h14 |=>
            o_hrdata[15:0] == {RELEASE_NO, $past(i_stat.baud_code)})
        else $error("status high");
    AST_LEAVE:
        assert property (o_cmd.leave_offline_cmd |-> o_cmd.start_timers ##1
            (o_online && !o_cmd.leave_offline_cmd && !o_cmd.go_offline_req))
        else $error("leave offline");
    AST_EOI:
        assert property (wr_s(32'h20) ##1 i_hwdata[1] |=> !o_int_allow [*8])
        else $error("eoi gap");
    AST_SWAP_SET:
        assert property (wr_s(32'h20) ##1 i_hwdata[4] |=> o_cmd.swap_enable)
        else $error("swap set");
    AST_SWAP_KEEP:
        assert property (wr_s(32'h24) ##1 !i_hwdata[4] |=>
            $stable(o_cmd.swap_enable)) else $error("swap keep");
    AST_FORCE:
        assert property (o_cmd.force_wait_prm && i_stat.slave_in_wait_prm
            |-> ##[1:2] !o_cmd.force_wait_prm) else $error("force clear");
    AST_GO_OFF:
        assert property (o_cmd.go_offline_req && !i_stat.request_busy
            |-> ##[1:3] !o_online && !o_cmd.go_offline_req)
        else $error("go offline");
    cover property (o_cmd.leave_offline_cmd);
    cover property (i_mem_addr > 11'h600);
    cover property (o_cmd.go_offline_req && !i_stat.request_busy);
endmodule
bind smsr_core smsr_checker #(.RELEASE_NO(RELEASE_NO),
    .GAP_LONG_CYC(GAP_LONG_CYC)) smsr_checker_i (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ahb(i_ahb), .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata), .i_stat(i_stat), .i_mem_addr(i_mem_addr),
    .o_mem_addr(o_mem_addr), .o_cmd(o_cmd), .o_online(o_online),
    .o_int_allow(o_int_allow));
`default_nettype wire

//--- test/tb_smsr_core.sv
// Self-checking bench for the control and status bank.
// Assumes the engine model answers the command outputs.
`timescale 1ns/1ps
`default_nettype none
module tb_smsr_core;
    localparam logic [3:0] REL = 4'h6; // Arbitrary value
    typedef struct packed {
        logic [9:0] st;
        logic [10:0] ma;
        logic [10:0] em;
        logic v;
    } smsr_row_t;
    smsr_row_t rows [10] = '{
        '{10'h000, 11'h000, 11'h000, 1'h0},
        '{10'h251, 11'h600, 11'h600, 1'h0},
        '{10'h1A2, 11'h601, 11'h201, 1'h1},
        '{10'h013, 11'h7FF, 11'h3FF, 1'h1},
        '{10'h344, 11'h000, 11'h000, 1'h1},
        '{10'h085, 11'h010, 11'h010, 1'h1},
        '{10'h026, 11'h010, 11'h010, 1'h1},
        '{10'h267, 11'h010, 11'h010, 1'h1},
        '{10'h198, 11'h010, 11'h010, 1'h1},
        '{10'h009, 11'h010, 11'h010, 1'h1}};
    logic i_clk = 1'h0;
    logic i_nrst = 1'h0;
    smsr_pkg::smsr_ahb_req_t ahb_q = '0;
    smsr_pkg::smsr_ahb_req_t ahb_w;
    smsr_pkg::smsr_stat_t stat;
    smsr_pkg::smsr_cmd_t cmd;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hready, hresp, online, allow, int_pend = 1'h0, mem_valid = 1'h0;
    logic [10:0] mem_addr = 11'h0, mem_out;
    logic [9:0] base = 10'h0;
    logic [15:0] preset;
    int error_cnt = 0, total_checks = 0, n;
    assign ahb_w = {ahb_q[39:1], hready};
    always #20 i_clk = ~i_clk;
    smsr_core #(.RELEASE_NO(REL), .GAP_LONG_CYC(50)) smsr_core_i (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ahb(ahb_w), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_stat(stat), .i_int_pending(int_pend), .i_mem_valid(mem_valid),
        .i_mem_addr(mem_addr), .o_mem_addr(mem_out), .o_cmd(cmd),
        .o_wdog_preset(preset), .o_online(online), .o_int_allow(allow));
    smsr_engine_model smsr_engine_model_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_cmd(cmd), .i_base({1'h0, base, 1'h0}), .i_busy_len(4'hC),
        .o_stat(stat));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge i_clk);
        ahb_q <= '{{24'h0, a}, 2'h2, w, 3'h2, 1'h1, 1'h0};
        do @(posedge i_clk); while (hready !== 1'h1);
        ahb_q.htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'h1);
        q = hrdata;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    // Gap after end of interrupt
    task automatic gap(input int exp);
        int c = 0;
        @(posedge i_clk);
        int_pend <= 1'h1;
        settle(2);
        chk(allow, 1);
        bus(1, 8'h20, 32'h02);
        settle(1);
        chk(allow, 0);
        while (allow !== 1'h1 && c < 200)
        begin
            settle(1);
            c++;
        end
        chk({c + 1 >= exp, c <= exp + 4}, 2'h3);
    endtask
    initial
    begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'h1;
        settle(0);
        chk({preset, cmd, online}, {16'hFFFF, 6'h00, 1'h0});
        chk({hready, hresp}, 2'h2);
        foreach (rows[k])
        begin
            @(posedge i_clk);
            base <= rows[k].st;
            mem_addr <= rows[k].ma;
            mem_valid <= 1'h1;
            bus(0, 8'h10, 0);
            chk(q, {rows[k].st[5:4], rows[k].st[7:6], rows[k].v,
                rows[k].st[8], rows[k].st[9], 1'h0});
            bus(0, 8'h14, 0);
            chk(q, {REL, rows[k].st[3:0]});
            chk(mem_out, rows[k].em);
        end
        bus(1, 8'h10, 32'hFF);
        bus(0, 8'h3C, 0);
        chk(q, 0);
        bus(0, 8'h10, 0);
        chk(q, 32'h08);
        bus(1, 8'h20, 32'h01);
        settle(2);
        chk({online, cmd.go_offline_req}, 2'h2);
        bus(0, 8'h10, 0);
        chk(q, 32'h01);
        bus(1, 8'h20, 32'h10);
        bus(1, 8'h24, 32'hEF);
        settle(1);
        chk(cmd.swap_enable, 1);
        bus(1, 8'h20, 32'hC0);
        bus(0, 8'h20, 0);
        chk(q, 32'h10);
        bus(1, 8'h24, 32'h10);
        settle(1);
        chk(cmd, 0);
        gap(25);
        bus(1, 8'h2C, 32'h01);
        gap(50);
        bus(1, 8'h28, 32'h1234);
        settle(1);
        chk(preset, 32'h1234);
        bus(0, 8'h28, 0);
        chk(q, 32'h1234);
        bus(1, 8'h20, 32'h20);
        n = 0;
        repeat (4) @(posedge i_clk) n += cmd.user_wdog_reload;
        chk(n, 1);
        base <= 10'h0A0;
        bus(1, 8'h20, 32'h08);
        bus(1, 8'h20, 32'h04);
        settle(1);
        chk(online, 1);
        n = 0;
        while (online !== 1'h0 && n < 30)
        begin
            settle(1);
            n++;
        end
        chk({online, cmd.go_offline_req, cmd.force_wait_prm}, 0);
        bus(0, 8'h10, 0);
        chk(q, 32'h80);
        tally_and_finish();
    end
endmodule
`default_nettype wire
